/* rtl/css_cfg_pkg.sv */
// Constants, command codes and field layouts of the packet configuration and transmit block.
//
// Contract
// - Calibrate after reset, then standby, busy low.
// - Carrier is count of 52MHz/2^18 steps.
// - Receive tuning sits IF below carrier.
// - Payload fetched from transmit base offset.
// - Spreading codes 0x50..0xC0 give SF5..SF12.
// - Bandwidth codes decode to four bandwidths.
// - Codes 1..4 give legacy interleaved rates.
// - Codes 5..7 give long interleaving rates.
// - Long interleaving shares detection memory.
// - Preamble is mantissa times two to exponent.
// - Header argument picks explicit or implicit.
// - Payload length accepted from 1 to 255.
// - CRC argument 0x20 enables, 0x00 disables.
// - IQ argument 0x40 standard, 0x00 inverted.
// - Buffer write stores bytes from given offset.
// - Transmit complete flag raised in standby.
// - Transmit carries base and 16-bit period count.
// - Completion or timeout returns to standby.
// - Clear command clears only masked flags.
// - Each DIO ORs its mapped flags.
package css_cfg_pkg;

  // ----------------------------------------------------------------
  // Command opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_ENTER_STANDBY = 8'h80;
  localparam logic [7:0] OP_SELECT_KIND = 8'h8A;
  localparam logic [7:0] OP_SET_CARRIER = 8'h86;
  localparam logic [7:0] OP_SET_BASES = 8'h8F;
  localparam logic [7:0] OP_SET_MODULATION = 8'h8B;
  localparam logic [7:0] OP_SET_FORMAT = 8'h8C;
  localparam logic [7:0] OP_SET_POWER_RAMP = 8'h8E;
  localparam logic [7:0] OP_BUFFER_WRITE = 8'h1A;
  localparam logic [7:0] OP_REGISTER_WRITE = 8'h18;
  localparam logic [7:0] OP_MAP_IRQ_PINS = 8'h8D;
  localparam logic [7:0] OP_START_TRANSMIT = 8'h83;
  localparam logic [7:0] OP_CLEAR_FLAGS = 8'h97;

  // ----------------------------------------------------------------
  // Argument values
  // ----------------------------------------------------------------
  localparam logic [7:0] CSS_PACKET_KIND = 8'h01;
  localparam logic [15:0] SF_TUNING_ADDR = 16'h0925;
  localparam logic [7:0] SF_TUNING_RESET = 8'h00;
  localparam logic [7:0] BW_CODE_1625 = 8'h0A;
  localparam logic [7:0] BW_CODE_812 = 8'h18;
  localparam logic [7:0] BW_CODE_406 = 8'h26;
  localparam logic [7:0] BW_CODE_203 = 8'h34;
  localparam logic [3:0] SF_MIN = 4'h5;
  localparam logic [3:0] SF_MAX = 4'hC;
  localparam logic [7:0] CR_FIRST = 8'h01;
  localparam logic [7:0] CR_LAST_LEGACY = 8'h04;
  localparam logic [7:0] CR_LI_4_5 = 8'h05;
  localparam logic [7:0] CR_LI_4_6 = 8'h06;
  localparam logic [7:0] LONG_INTERLEAVE_RATE_4_8 = 8'h07;
  localparam logic [7:0] HDR_EXPLICIT = 8'h00;
  localparam logic [7:0] HDR_IMPLICIT = 8'h80;
  localparam logic [7:0] CRC_ON = 8'h20;
  localparam logic [7:0] CRC_OFF = 8'h00;
  localparam logic [7:0] IQ_STD = 8'h40;
  localparam logic [7:0] IQ_INV = 8'h00;

  // ----------------------------------------------------------------
  // Flag bit positions and reset values
  // ----------------------------------------------------------------
  localparam int FLAG_TX_DONE = 0;
  localparam int FLAG_TIMEOUT = 14;
  localparam logic [15:0] FLAGS_RESET = 16'h0000;
  localparam logic [23:0] CARRIER_RESET = 24'h00_0000;
  localparam logic [7:0] LEN_RESET = 8'h01;

  // ----------------------------------------------------------------
  // Synthesizer step and intermediate frequency
  // ----------------------------------------------------------------
  localparam longint XTAL_HZ = 52000000;
  localparam int STEP_SHIFT = 18;
  localparam longint IF_HZ = 1650000;
  // Intermediate frequency expressed in synthesizer steps, rounded to nearest.
  localparam logic [23:0] IF_STEPS = 24'(((IF_HZ << STEP_SHIFT) + XTAL_HZ / 2) / XTAL_HZ);

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam logic [15:0] CAL_CYCLES = 16'h0040;

  // Operating modes of the device.
  typedef enum logic [1:0] {
    MODE_CALIB = 2'b00,
    MODE_STANDBY = 2'b01,
    MODE_TX = 2'b10
  } mode_type;

  // Transmit fetch sequence.
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_LOAD = 2'b01,
    TX_PRESENT = 2'b10,
    TX_HOLD = 2'b11
  } tx_state_type;

endpackage : css_cfg_pkg

/* rtl/css_data_buffer.sv */
// Payload data memory with one write port and one registered read port.
`timescale 1ns/10ps
`default_nettype none
module css_data_buffer (
  input wire logic mclk,
  input wire logic wr_en,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // No reset on the array so that it maps onto plain memory.
  logic [7:0] mem [0:255];

  // Write port.
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Read port, one cycle of latency.
  always_ff @(posedge mclk) begin
    rd_data <= mem[rd_addr];
  end

endmodule : css_data_buffer
`default_nettype wire

/* rtl/css_packet_config_and_tx.sv */
// Command interpreter, configuration store and transmit sequencer for the spread-spectrum packet mode.
`timescale 1ns/10ps
`default_nettype none
module css_packet_config_and_tx
  import css_cfg_pkg::*;
#(
  parameter logic [23:0] STEP_CYCLES_0 = 24'h00_0010,
  parameter logic [23:0] STEP_CYCLES_1 = 24'h00_0040,
  parameter logic [23:0] STEP_CYCLES_2 = 24'h00_0100,
  parameter logic [23:0] STEP_CYCLES_3 = 24'h00_0400
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic cmd_last,
  output logic busy,
  output logic rc_standby_state,
  output logic [7:0] packet_kind,
  output logic [23:0] carrier_step_count,
  output logic [23:0] rx_tune_step_count,
  output logic [7:0] transmit_base_offset,
  output logic [7:0] receive_base_offset,
  output logic [3:0] spreading_factor,
  output logic [1:0] bandwidth_sel,
  output logic [1:0] coding_rate_sel,
  output logic long_interleave,
  output logic detect_mem_shared,
  output logic [19:0] preamble_symbols,
  output logic implicit_header,
  output logic [7:0] payload_length,
  output logic crc_enable,
  output logic iq_standard,
  output logic [7:0] power_arg,
  output logic [7:0] ramp_arg,
  output logic [7:0] sf_dependent_tuning,
  output logic [15:0] irq_flags,
  output logic dio1,
  output logic dio2,
  output logic dio3,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // Spreading code is valid when the low nibble is zero and the high nibble is 5..12.
  function automatic logic sf_ok(input logic [7:0] code);
    sf_ok = (code[3:0] == 4'h0) && (code[7:4] >= SF_MIN) && (code[7:4] <= SF_MAX);
  endfunction : sf_ok

  // Step length in clock cycles for a timeout base code.
  function automatic logic [23:0] step_len(input logic [1:0] base);
    unique case (base)
      2'b00: step_len = STEP_CYCLES_0;
      2'b01: step_len = STEP_CYCLES_1;
      2'b10: step_len = STEP_CYCLES_2;
      2'b11: step_len = STEP_CYCLES_3;
    endcase
  endfunction : step_len

  // ----------------------------------------------------------------
  // State declarations
  // ----------------------------------------------------------------
  mode_type mode_r;
  tx_state_type tx_state_r;
  logic [15:0] cal_cnt_r;
  logic [7:0] opcode_r;
  logic [3:0] arg_cnt_r;
  logic [7:0] args_r [0:7];
  logic in_frame_r;
  logic exec_r;
  logic [7:0] wr_ptr_r;
  logic buf_wr_en;
  logic [7:0] rd_data;
  logic [7:0] tx_ptr_r;
  logic [7:0] tx_left_r;
  logic [15:0] irq_mask_r;
  logic [15:0] dio1_mask_r;
  logic [15:0] dio2_mask_r;
  logic [15:0] dio3_mask_r;
  logic [15:0] flag_set;
  logic [15:0] flag_clr;
  logic [15:0] period_left_r;
  logic [23:0] step_left_r;
  logic [1:0] base_r;
  logic timeout_armed_r;
  logic tx_finish;
  logic tx_timeout;
  logic cmd_take;
  logic [15:0] tx_count_arg;

  // A byte is taken only while not busy; bytes offered while busy are dropped.
  assign cmd_take = cmd_valid && !busy;
  assign tx_count_arg = {args_r[1], args_r[2]};

  // ----------------------------------------------------------------
  // Calibration and busy
  // ----------------------------------------------------------------
  // Busy covers calibration and the execution cycle of each command.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cal_cnt_r <= 16'h0000;
    end else if (mode_r == MODE_CALIB) begin
      cal_cnt_r <= cal_cnt_r + 16'h0001;
    end
  end

  assign busy = (mode_r == MODE_CALIB) || exec_r;
  assign rc_standby_state = (mode_r == MODE_STANDBY);

  // ----------------------------------------------------------------
  // Command framing
  // ----------------------------------------------------------------
  // The opcode is the first byte; up to eight argument bytes are kept.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      opcode_r <= 8'h00;
      arg_cnt_r <= 4'h0;
      in_frame_r <= 1'b0;
      exec_r <= 1'b0;
    end else begin
      exec_r <= 1'b0;
      if (cmd_take) begin
        if (!in_frame_r) begin
          opcode_r <= cmd_byte;
          arg_cnt_r <= 4'h0;
        end else if (arg_cnt_r != 4'h8) begin
          arg_cnt_r <= arg_cnt_r + 4'h1;
        end
        in_frame_r <= !cmd_last;
        exec_r <= cmd_last;
      end
    end
  end

  // Argument capture; extra bytes beyond eight are only used by buffer writes.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 8; i++) begin
        args_r[i] <= 8'h00;
      end
    end else if (cmd_take && in_frame_r && arg_cnt_r != 4'h8) begin
      args_r[arg_cnt_r[2:0]] <= cmd_byte;
    end
  end

  // ----------------------------------------------------------------
  // Buffer write streaming
  // ----------------------------------------------------------------
  // The first argument is the offset; later bytes land at consecutive addresses, wrapping at 256.
  assign buf_wr_en = cmd_take && in_frame_r && (opcode_r == OP_BUFFER_WRITE) && (arg_cnt_r != 4'h0);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_r <= 8'h00;
    end else if (cmd_take && in_frame_r && opcode_r == OP_BUFFER_WRITE) begin
      wr_ptr_r <= (arg_cnt_r == 4'h0) ? cmd_byte : wr_ptr_r + 8'h01;
    end
  end

  css_data_buffer u_buf (
    .mclk(mclk),
    .wr_en(buf_wr_en),
    .wr_addr((arg_cnt_r == 4'h0) ? cmd_byte : wr_ptr_r),
    .wr_data(cmd_byte),
    .rd_addr(tx_ptr_r),
    .rd_data(rd_data)
  );

  // ----------------------------------------------------------------
  // Radio and addressing configuration
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      packet_kind <= 8'h00;
      carrier_step_count <= CARRIER_RESET;
      rx_tune_step_count <= CARRIER_RESET;
      transmit_base_offset <= 8'h00;
      receive_base_offset <= 8'h00;
      power_arg <= 8'h00;
      ramp_arg <= 8'h00;
      sf_dependent_tuning <= SF_TUNING_RESET;
    end else if (exec_r) begin
      unique case (opcode_r)
        OP_SELECT_KIND: begin
          packet_kind <= args_r[0];
        end
        OP_SET_CARRIER: begin
          carrier_step_count <= {args_r[0], args_r[1], args_r[2]};
          rx_tune_step_count <= {args_r[0], args_r[1], args_r[2]} - IF_STEPS;
        end
        OP_SET_BASES: begin
          transmit_base_offset <= args_r[0];
          receive_base_offset <= args_r[1];
        end
        OP_SET_POWER_RAMP: begin
          power_arg <= args_r[0];
          ramp_arg <= args_r[1];
        end
        OP_REGISTER_WRITE: begin
          if ({args_r[0], args_r[1]} == SF_TUNING_ADDR) begin
            sf_dependent_tuning <= args_r[2];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Modulation parameters
  // ----------------------------------------------------------------
  // Codes outside the tables leave the previous setting untouched.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      spreading_factor <= SF_MIN;
      bandwidth_sel <= 2'b00;
      coding_rate_sel <= 2'b00;
      long_interleave <= 1'b0;
    end else if (exec_r && opcode_r == OP_SET_MODULATION) begin
      if (sf_ok(args_r[0])) begin
        spreading_factor <= args_r[0][7:4];
      end
      unique case (args_r[1])
        BW_CODE_1625: bandwidth_sel <= 2'b00;
        BW_CODE_812: bandwidth_sel <= 2'b01;
        BW_CODE_406: bandwidth_sel <= 2'b10;
        BW_CODE_203: bandwidth_sel <= 2'b11;
        default: begin
        end
      endcase
      if (args_r[2] >= CR_FIRST && args_r[2] <= CR_LAST_LEGACY) begin
        coding_rate_sel <= 2'(args_r[2] - CR_FIRST);
        long_interleave <= 1'b0;
      end else if (args_r[2] == CR_LI_4_5 || args_r[2] == CR_LI_4_6) begin
        coding_rate_sel <= 2'(args_r[2] - CR_LI_4_5);
        long_interleave <= 1'b1;
      end else if (args_r[2] == LONG_INTERLEAVE_RATE_4_8) begin
        coding_rate_sel <= 2'b11;
        long_interleave <= 1'b1;
      end
    end
  end

  // The detection memory is lent to the coder whenever long interleaving is on, in either header mode.
  assign detect_mem_shared = long_interleave;

  // ----------------------------------------------------------------
  // Packet format
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      preamble_symbols <= 20'h0_0002;
      implicit_header <= 1'b0;
      payload_length <= LEN_RESET;
      crc_enable <= 1'b0;
      iq_standard <= 1'b1;
    end else if (exec_r && opcode_r == OP_SET_FORMAT) begin
      if (args_r[0][3:0] != 4'h0 && args_r[0][7:4] != 4'h0) begin
        preamble_symbols <= 20'(args_r[0][3:0]) << args_r[0][7:4];
      end
      if (args_r[1] == HDR_EXPLICIT) begin
        implicit_header <= 1'b0;
      end else if (args_r[1] == HDR_IMPLICIT) begin
        implicit_header <= 1'b1;
      end
      if (args_r[2] != 8'h00) begin
        payload_length <= args_r[2];
      end
      if (args_r[3] == CRC_ON) begin
        crc_enable <= 1'b1;
      end else if (args_r[3] == CRC_OFF) begin
        crc_enable <= 1'b0;
      end
      if (args_r[4] == IQ_STD) begin
        iq_standard <= 1'b1;
      end else if (args_r[4] == IQ_INV) begin
        iq_standard <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Flag masks and pin mapping
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      irq_mask_r <= FLAGS_RESET;
      dio1_mask_r <= FLAGS_RESET;
      dio2_mask_r <= FLAGS_RESET;
      dio3_mask_r <= FLAGS_RESET;
    end else if (exec_r && opcode_r == OP_MAP_IRQ_PINS) begin
      irq_mask_r <= {args_r[0], args_r[1]};
      dio1_mask_r <= {args_r[2], args_r[3]};
      dio2_mask_r <= {args_r[4], args_r[5]};
      dio3_mask_r <= {args_r[6], args_r[7]};
    end
  end

  // Only flags enabled in the global mask may be raised.
  always_comb begin
    flag_set = FLAGS_RESET;
    flag_set[FLAG_TX_DONE] = tx_finish;
    flag_set[FLAG_TIMEOUT] = tx_timeout;
    flag_set = flag_set & irq_mask_r;
    flag_clr = (exec_r && opcode_r == OP_CLEAR_FLAGS) ? {args_r[0], args_r[1]} : FLAGS_RESET;
  end

  // A flag raised in the cycle it is cleared survives.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      irq_flags <= FLAGS_RESET;
    end else begin
      irq_flags <= (irq_flags & ~flag_clr) | flag_set;
    end
  end

  assign dio1 = |(irq_flags & dio1_mask_r);
  assign dio2 = |(irq_flags & dio2_mask_r);
  assign dio3 = |(irq_flags & dio3_mask_r);

  // ----------------------------------------------------------------
  // Operating mode
  // ----------------------------------------------------------------
  // Transmit only starts from standby with the spread-spectrum kind selected.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mode_r <= MODE_CALIB;
    end else begin
      unique case (mode_r)
        MODE_CALIB: begin
          if (cal_cnt_r == CAL_CYCLES - 16'h0001) begin
            mode_r <= MODE_STANDBY;
          end
        end
        MODE_STANDBY: begin
          if (exec_r && opcode_r == OP_START_TRANSMIT && packet_kind == CSS_PACKET_KIND) begin
            mode_r <= MODE_TX;
          end
        end
        MODE_TX: begin
          if (tx_finish || tx_timeout || (exec_r && opcode_r == OP_ENTER_STANDBY)) begin
            mode_r <= MODE_STANDBY;
          end
        end
        default: begin
          mode_r <= MODE_STANDBY;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Transmit timeout
  // ----------------------------------------------------------------
  // A zero period count leaves the timer disarmed for the whole packet.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      timeout_armed_r <= 1'b0;
      period_left_r <= 16'h0000;
      step_left_r <= 24'h00_0000;
      base_r <= 2'b00;
    end else if (mode_r == MODE_STANDBY && exec_r && opcode_r == OP_START_TRANSMIT) begin
      base_r <= args_r[0][1:0];
      timeout_armed_r <= (tx_count_arg != 16'h0000);
      period_left_r <= tx_count_arg;
      step_left_r <= step_len(args_r[0][1:0]);
    end else if (mode_r != MODE_TX) begin
      timeout_armed_r <= 1'b0;
    end else if (timeout_armed_r) begin
      if (step_left_r == 24'h00_0001) begin
        step_left_r <= step_len(base_r);
        period_left_r <= period_left_r - 16'h0001;
      end else begin
        step_left_r <= step_left_r - 24'h00_0001;
      end
    end
  end

  assign tx_timeout = (mode_r == MODE_TX) && timeout_armed_r && (period_left_r == 16'h0001)
                      && (step_left_r == 24'h00_0001) && !tx_finish;

  // ----------------------------------------------------------------
  // Payload fetch and hand-off to the modulator
  // ----------------------------------------------------------------
  // Each byte costs a memory read cycle, trading throughput for a single read port.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tx_state_r <= TX_IDLE;
      tx_ptr_r <= 8'h00;
      tx_left_r <= 8'h00;
      tx_data <= 8'h00;
      tx_valid <= 1'b0;
    end else if (mode_r != MODE_TX || tx_timeout || (exec_r && opcode_r == OP_ENTER_STANDBY)) begin
      tx_valid <= 1'b0;
      tx_state_r <= TX_IDLE;
      tx_ptr_r <= transmit_base_offset;
      tx_left_r <= payload_length;
      if (mode_r == MODE_STANDBY && exec_r && opcode_r == OP_START_TRANSMIT && packet_kind == CSS_PACKET_KIND) begin
        tx_state_r <= TX_LOAD;
      end
    end else begin
      unique case (tx_state_r)
        TX_IDLE: begin
          tx_valid <= 1'b0;
        end
        TX_LOAD: begin
          tx_state_r <= TX_PRESENT;
        end
        TX_PRESENT: begin
          tx_data <= rd_data;
          tx_valid <= 1'b1;
          tx_state_r <= TX_HOLD;
        end
        TX_HOLD: begin
          if (tx_ready) begin
            tx_valid <= 1'b0;
            tx_ptr_r <= tx_ptr_r + 8'h01;
            tx_left_r <= tx_left_r - 8'h01;
            tx_state_r <= (tx_left_r == 8'h01) ? TX_IDLE : TX_LOAD;
          end
        end
      endcase
    end
  end

  // The last accepted byte ends the packet; mode drops to standby at the same edge the flag rises.
  assign tx_finish = (mode_r == MODE_TX) && (tx_state_r == TX_HOLD) && tx_ready && (tx_left_r == 8'h01);

endmodule : css_packet_config_and_tx
`default_nettype wire

/* bench/css_tx_sink.sv */
// Modulator stand-in that accepts payload bytes and stalls on demand.
`timescale 1ns/10ps
`default_nettype none
module css_tx_sink (
  input wire logic mclk,
  input wire logic stall,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready
);
  logic [7:0] got[$];
  logic ph = 1'b0;
  // Ready only on alternate cycles, so the device must hold each byte.
  always @(posedge mclk) begin
    if (tx_valid && tx_ready) got.push_back(tx_data);
    ph <= ~ph;
  end
  assign tx_ready = ph && !stall;
endmodule : css_tx_sink
`default_nettype wire

/* bench/css_cfg_chk.sv */
// Assertion checker for the command and transmit ports.
`timescale 1ns/10ps
`default_nettype none
module css_cfg_chk (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic busy,
  input wire logic rc_standby_state,
  input wire logic [15:0] irq_flags,
  input wire logic dio2,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_ready
);
  // A held byte may vanish only when an abort or timeout returns to standby.
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!arst_n);
  a_exec_one_cycle: assert property ($rose(busy) |=> !busy) else $error("busy too long");
  a_done_in_standby: assert property ($rose(irq_flags[0]) |-> rc_standby_state) else $error("done early");
  a_done_after_tx: assert property ($rose(irq_flags[0]) |-> $past(!rc_standby_state)) else $error("done idle");
  a_timeout_ends_tx: assert property ($rose(irq_flags[14]) |-> rc_standby_state && !tx_valid) else $error("tmo");
  a_standby_quiet: assert property (rc_standby_state |-> !tx_valid) else $error("byte in standby");
  a_byte_held: assert property (tx_valid && !tx_ready |=> (tx_valid && $stable(tx_data)) || rc_standby_state)
    else $error("byte dropped");
  a_byte_paced: assert property (tx_valid && tx_ready |=> !tx_valid) else $error("byte repeated");
  a_flags_hold: assert property (!busy |=> (irq_flags & $past(irq_flags)) == $past(irq_flags))
    else $error("flag lost");
  a_dio_quiet: assert property (irq_flags == 16'h0000 |-> !dio2) else $error("pin high");
  c_accept: cover property (tx_valid && tx_ready);
  c_done: cover property ($rose(irq_flags[0]));
  c_timeout: cover property ($rose(irq_flags[14]));
endmodule : css_cfg_chk
bind css_packet_config_and_tx css_cfg_chk css_cfg_chk_i (.*);
`default_nettype wire

/* bench/css_packet_config_and_tx_tb_top.sv */
// Self-checking bench comparing the block outputs with expected values computed inline.
`timescale 1ns/10ps
`default_nettype none
module css_packet_config_and_tx_tb_top;
  import css_cfg_pkg::*;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_last = 1'b0;
  logic stall = 1'b1;
  logic [7:0] cmd_byte = 8'h00;
  logic busy, rc_standby_state, long_interleave, implicit_header, crc_enable, iq_standard, dio1, dio2, tx_valid, tx_ready;
  logic [23:0] carrier_step_count, rx_tune_step_count;
  logic [7:0] transmit_base_offset, payload_length, sf_dependent_tuning, tx_data;
  logic [3:0] spreading_factor;
  logic [1:0] bandwidth_sel, coding_rate_sel;
  logic [19:0] preamble_symbols;
  logic [7:0] receive_base_offset, packet_kind, power_arg, ramp_arg;
  logic detect_mem_shared, dio3;
  logic [15:0] irq_flags;
  logic [31:0] rs = 32'h0d5e_23cb;
  int miscompares = 0;
  int tests_run = 0;
  // Two-cycle timeout step keeps the timeout run short.
  css_packet_config_and_tx #(.STEP_CYCLES_0(24'h00_0002)) css_packet_config_and_tx_i (.*);
  css_tx_sink css_tx_sink_i (.*);
  always #2 mclk = ~mclk;
  function logic [7:0] rb();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs[7:0];
  endfunction : rb
  task print_verdict();
    if (miscompares == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %h %h", $time, got, exp);
    end
  endtask : chk
  // Waits for busy low (b < 0) or a flag; running out of cycles ends the run.
  task until_flag(input int b);
    int n;
    n = 0;
    while ((b < 0 ? busy !== 1'b0 : irq_flags[b] !== 1'b1) && n < 300) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n == 300) begin
      miscompares++;
      print_verdict();
    end
  endtask : until_flag
  task send(input logic [7:0] q[$]);
    foreach (q[i]) begin
      until_flag(-1);
      cmd_valid = 1'b1;
      cmd_byte = q[i];
      cmd_last = (i == q.size() - 1);
      @(posedge mclk);
      #1;
    end
    cmd_valid = 1'b0;
    @(posedge mclk);
    #1;
    until_flag(-1);
  endtask : send
  initial begin
    logic [23:0] c;
    logic [7:0] v;
    logic [3:0] m, e;
    logic [7:0] p[$];
    logic [7:0] bw[4];
    int j, k;
    bw = '{BW_CODE_1625, BW_CODE_812, BW_CODE_406, BW_CODE_203};
    repeat (2) @(posedge mclk);
    #1;
    arst_n = 1'b1;
    chk(busy, 1'b1);
    chk(sf_dependent_tuning, SF_TUNING_RESET);
    until_flag(-1);
    chk(rc_standby_state, 1'b1);
    c = {rb(), rb(), rb()};
    send('{OP_SET_CARRIER, c[23:16], c[15:8], c[7:0]});
    chk(carrier_step_count, c);
    chk(rx_tune_step_count, 24'(c - IF_STEPS));
    // Every spreading, bandwidth and coding code, then a set with invalid spreading and coding codes.
    for (int i = 0; i < 9; i++) begin
      j = (i == 8) ? 7 : i;
      k = j % 7;
      send('{OP_SET_MODULATION, i == 8 ? 8'hC5 : 8'(8'h50 + 16 * i), bw[i % 4], i == 8 ? 8'h00 : 8'(k + 1)});
      chk(spreading_factor, 5 + j);
      chk(bandwidth_sel, i % 4);
      chk(coding_rate_sel, k < 4 ? k : (k == 6 ? 3 : k - 4));
      chk(long_interleave, k > 3);
      chk(detect_mem_shared, k > 3);
    end
    for (int i = 0; i < 2; i++) begin
      m = i ? 4'h3 : 4'(rb() % 15 + 1);
      e = i ? 4'h2 : 4'(rb() % 15 + 1);
      v = i ? 8'h04 : 8'(rb() % 255 + 1);
      send('{OP_SET_FORMAT, {e, m}, i ? HDR_IMPLICIT : HDR_EXPLICIT, v, i ? CRC_ON : CRC_OFF, i ? IQ_INV : IQ_STD});
      chk(preamble_symbols, 32'(m) << e);
      chk(implicit_header, i);
      chk(payload_length, v);
      chk(crc_enable, i);
      chk(iq_standard, !i);
    end
    // Spreading factor is 12 here, so the host owes the matching tuning value; other addresses are ignored.
    v = rb();
    send('{OP_REGISTER_WRITE, 8'h09, 8'h25, 8'h32});
    send('{OP_REGISTER_WRITE, 8'h09, 8'h26, v});
    chk(sf_dependent_tuning, 8'h32);
    v = rb();
    send('{OP_SET_BASES, v, c[7:0]});
    chk(transmit_base_offset, v);
    chk(receive_base_offset, c[7:0]);
    repeat (4) p.push_back(rb());
    send({OP_BUFFER_WRITE, v, p});
    send('{OP_SELECT_KIND, CSS_PACKET_KIND});
    chk(packet_kind, CSS_PACKET_KIND);
    send('{OP_SET_POWER_RAMP, c[15:8], c[23:16]});
    chk(power_arg, c[15:8]);
    chk(ramp_arg, c[23:16]);
    send('{OP_MAP_IRQ_PINS, 8'h40, 8'h01, 8'h00, 8'h01, 8'h40, 8'h00, 8'h40, 8'h01});
    // Modulator stalled, so only the timeout can end this transmission.
    send('{OP_START_TRANSMIT, 8'h00, 8'h00, 8'h03});
    until_flag(FLAG_TIMEOUT);
    chk(rc_standby_state, 1'b1);
    chk(css_tx_sink_i.got.size(), 0);
    // With a zero count the stalled transmit has no timer, so only a standby command ends it.
    send('{OP_START_TRANSMIT, 8'h00, 8'h00, 8'h00});
    chk(rc_standby_state, 1'b0);
    send('{OP_ENTER_STANDBY, 8'h00});
    chk(rc_standby_state, 1'b1);
    chk(tx_valid, 1'b0);
    stall = 1'b0;
    send('{OP_START_TRANSMIT, 8'h00, 8'h00, 8'h00});
    until_flag(FLAG_TX_DONE);
    chk(rc_standby_state, 1'b1);
    foreach (p[i]) chk(css_tx_sink_i.got[i], p[i]);
    chk(dio1, 1'b1);
    send('{OP_CLEAR_FLAGS, 8'h00, 8'h01});
    chk(irq_flags, 16'h4000);
    chk(dio1, 1'b0);
    chk(dio2, 1'b1);
    chk(dio3, 1'b1);
    print_verdict();
  end
endmodule : css_packet_config_and_tx_tb_top
`default_nettype wire
